// ===== pmsw_pkg.sv
// Purpose: constants and types for the switch and buck-one configuration
// Assumes: 10 MHz clk, 8-bit register port, same-clock commit strobes
// Notes: every offset, reset value and field position lives here; the switch count of 3 is fixed in pmsw_top
// Function
// - warm-reset select 1: pin three is buck 1/2 warm-reset input, else output
// - third switch limit bits 3-2: 100, 200, 500, 1000 mA; reset 00b
// - second switch limit bits 1-0: 100, 200, 500, 1000 mA; reset 00b
// - failoff bits 5..3 force switch off while power-fail output is low
// - discharge bits 2..0 enable active discharge while switch is off
// - each accepted buck-one write blanks over/under-voltage monitoring for 5 ms
// - buck-one code applies only after a commit or commit-with-discharge
// - buck-one bit 7 enables light-load pfm, resets to 1; 0 forces pwm
// - buck-one code bits 5-0 map linearly 0.850 V to 1.200 V, 10 mV steps
// - the three registers take writes only after the password unlock
// - reset values: 0x14 reads 0x40, 0x15 reads 0x00, 0x16 reads 0x80
package pmsw_pkg;
    // ========================================
    // register map
    localparam logic [7:0] OFS_UNLOCK = 8'h10;
    localparam logic [7:0] OFS_LIMIT = 8'h14;
    localparam logic [7:0] OFS_FAILSAFE = 8'h15;
    localparam logic [7:0] OFS_BUCK = 8'h16;
    localparam logic [7:0] OFS_COMMIT = 8'h1A;
    localparam logic [7:0] UNLOCK_KEY = 8'h5A;
    localparam logic [7:0] RST_LIMIT = 8'h40;
    localparam logic [7:0] RST_FAILSAFE = 8'h00;
    localparam logic [7:0] RST_BUCK = 8'h80;
    localparam logic [7:0] MASK_LIMIT = 8'hCF;
    localparam logic [7:0] MASK_FAILSAFE = 8'h3F;
    localparam logic [7:0] MASK_BUCK = 8'hBF;
    // ========================================
    // field positions
    localparam int BIT_WARM_RST = 7;
    localparam int BIT_UVLO_HYS = 6;
    localparam int FLD_LS3_LO = 2;
    localparam int FLD_LS2_LO = 0;
    localparam int FLD_FAILOFF_LO = 3;
    localparam int FLD_DISCH_LO = 0;
    localparam int BIT_PFM = 7;
    localparam int CODE_W = 6;
    localparam int UNLOCK_BIT_ARMED = 0;
    localparam int UNLOCK_BIT_REJECT = 1;
    // ========================================
    // decoded values
    localparam logic [10:0] ILIM_0_MA = 11'h064;
    localparam logic [10:0] ILIM_1_MA = 11'h0C8;
    localparam logic [10:0] ILIM_2_MA = 11'h1F4;
    localparam logic [10:0] ILIM_3_MA = 11'h3E8;
    localparam int VOUT_BASE_MV = 850;
    localparam int VOUT_STEP_MV = 10;
    localparam logic [5:0] VOUT_LINEAR_MAX = 6'h23;
    // ========================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int BLANK_TIME_US = 5000;
    localparam int BLANK_CYCLES = (BLANK_TIME_US * 1000) / CLK_PERIOD_NS;
    typedef enum {PMSW_LOCKED, PMSW_ARMED} pmsw_lock_t;
endpackage

// ===== pmsw_blank_if.sv
// Purpose: carries the blanking start and state between top and timer
// Assumes: one clock domain
// Notes: start is a one-cycle pulse, active a level
`timescale 1ns/1ns
interface pmsw_blank_if;
    logic start;
    logic active;
    modport ctl (output start, input active);
    modport tmr (input start, output active);
endinterface

// ===== pmsw_sync3.sv
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: output changes only once stages two and three agree
`timescale 1ns/1ns
module pmsw_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;

    // ========================================
    // capture chain; ff1 feeds only ff2 to keep metastability contained
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ff1 <= RST_VAL;
            ff2 <= RST_VAL;
            ff3 <= RST_VAL;
        end else if (ce) begin
            ff1 <= async_in;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    // accept per bit only when the last two stages agree (filters a glitch)
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                sync_out[i] <= RST_VAL[i];
            end else if (ce && (ff2[i] == ff3[i])) begin
                sync_out[i] <= ff3[i];
            end
        end
    end
endmodule

// ===== pmsw_blank_timer.sv
// Purpose: monitor blanking window after a buck-one write
// Assumes: start pulses are qualified with the clock enable
// Notes: a new start reloads the full window
`timescale 1ns/1ns
module pmsw_blank_timer #(
    parameter int CYCLES = 50000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    pmsw_blank_if.tmr blk
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    logic [CW-1:0] remain;

    // ========================================
    // countdown; restarting on every write keeps the full window
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            remain <= '0;
        end else if (ce) begin
            if (blk.start) begin
                remain <= LOAD;
            end else if (remain != '0) begin
                remain <= remain - CW'(1);
            end
        end
    end

    assign blk.active = (remain != '0);

    a_blank_hold: assert property (@(posedge clk) disable iff (!rstn)
        (ce && blk.start) |=> blk.active[*2])
        else $error("blanking window did not open after start");
    a_blank_load: assert property (@(posedge clk) disable iff (!rstn)
        (ce && blk.start) |=> (remain == LOAD))
        else $error("blanking counter not loaded with full window");
endmodule

// ===== pmsw_top.sv
// Purpose: password-protected switch and buck-one configuration registers
// Assumes: register port on clk; commit strobes come from same-clock logic
// Notes: applied voltage code moves only on commit, not on register write
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module pmsw_top import pmsw_pkg::*; #(
    parameter int BLANK_CYCLES_P = BLANK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic commit_go,
    input wire logic commit_go_discharge,
    input wire logic power_fail_out_low,
    input wire logic [2:0] switch_enable,
    input wire logic gpo_three_level,
    input wire logic general_pin_three_in,
    output logic general_pin_three_out,
    output logic general_pin_three_oe_n,
    output logic buck_warm_reset,
    output logic undervolt_hysteresis_sel,
    output logic [10:0] third_switch_limit_ma,
    output logic [10:0] second_switch_limit_ma,
    output logic [2:0] switch_on,
    output logic [2:0] switch_discharge,
    output logic buck_one_pfm,
    output logic [5:0] buck_one_code_applied,
    output logic [10:0] buck_one_target_mv,
    output logic buck_commit_discharge,
    output logic buck_monitor_blank,
    input wire logic [1:0] ov_uv_raw,
    output logic [1:0] ov_uv_fault
);
    logic [7:0] switch_limit_config;
    logic [7:0] switch_failsafe_config;
    logic [7:0] buck_one_voltage;
    pmsw_lock_t lock_state;
    logic write_rejected;
    logic pfo_low_sync;
    logic pin3_sync;
    logic prot_hit;
    logic wr_ok;
    logic commit_any;
    pmsw_blank_if blank_bus();

    // ========================================
    // pin synchronisers
    pmsw_sync3 #(.W(2), .RST_VAL(2'h3)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .async_in({power_fail_out_low, general_pin_three_in}),
        .sync_out({pfo_low_sync, pin3_sync})
    );

    // ========================================
    // password unlock: key write arms, next write of any other kind disarms
    assign prot_hit = (reg_addr == OFS_LIMIT) || (reg_addr == OFS_FAILSAFE)
                      || (reg_addr == OFS_BUCK);
    assign wr_ok = reg_wr && prot_hit && (lock_state == PMSW_ARMED);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lock_state <= PMSW_LOCKED;
        end else if (ce && reg_wr) begin
            if (reg_addr == OFS_UNLOCK && reg_wdata == UNLOCK_KEY) begin
                lock_state <= PMSW_ARMED;
            end else begin
                lock_state <= PMSW_LOCKED;
            end
        end
    end

    // rejected-write flag: a new rejection beats the clearing read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            write_rejected <= 1'b0;
        end else if (ce) begin
            if (reg_wr && prot_hit && lock_state != PMSW_ARMED) begin
                write_rejected <= 1'b1;
            end else if (reg_rd && reg_addr == OFS_UNLOCK) begin
                write_rejected <= 1'b0;
            end
        end
    end

    // ========================================
    // configuration registers, reserved bits masked off on write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            switch_limit_config <= RST_LIMIT;
            switch_failsafe_config <= RST_FAILSAFE;
            buck_one_voltage <= RST_BUCK;
        end else if (ce && wr_ok) begin
            case (reg_addr)
                OFS_LIMIT: begin
                    switch_limit_config <= reg_wdata & MASK_LIMIT;
                end
                OFS_FAILSAFE: begin
                    switch_failsafe_config <= reg_wdata & MASK_FAILSAFE;
                end
                OFS_BUCK: begin
                    buck_one_voltage <= reg_wdata & MASK_BUCK;
                end
                default: begin
                end
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            if (reg_rd) begin
                case (reg_addr)
                    OFS_LIMIT: reg_rdata <= switch_limit_config;
                    OFS_FAILSAFE: reg_rdata <= switch_failsafe_config;
                    OFS_BUCK: reg_rdata <= buck_one_voltage;
                    OFS_UNLOCK: begin
                        reg_rdata <= 8'h00;
                        reg_rdata[UNLOCK_BIT_ARMED] <=
                            (lock_state == PMSW_ARMED);
                        reg_rdata[UNLOCK_BIT_REJECT] <= write_rejected;
                    end
                    default: reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ========================================
    // monitor blanking on every accepted buck-one write
    assign blank_bus.start = ce && wr_ok && (reg_addr == OFS_BUCK);

    pmsw_blank_timer #(.CYCLES(BLANK_CYCLES_P)) u_blank (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .blk(blank_bus.tmr)
    );

    // faults are held off while blanking so a voltage step cannot trip them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buck_monitor_blank <= 1'b0;
            ov_uv_fault <= 2'h0;
        end else if (ce) begin
            buck_monitor_blank <= blank_bus.active;
            ov_uv_fault <= blank_bus.active ? 2'h0 : ov_uv_raw;
        end
    end

    // ========================================
    // commit: code reaches the converter only on a commit strobe
    assign commit_any = commit_go || commit_go_discharge;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buck_one_code_applied <= 6'h00;
            buck_commit_discharge <= 1'b0;
        end else if (ce) begin
            buck_commit_discharge <= commit_go_discharge;
            if (commit_any) begin
                buck_one_code_applied <= buck_one_voltage[CODE_W-1:0];
            end
        end
    end

    // linear map; codes above the linear end are outside this block's scope
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buck_one_target_mv <= 11'(VOUT_BASE_MV);
        end else if (ce) begin
            buck_one_target_mv <= 11'(VOUT_BASE_MV + VOUT_STEP_MV *
                int'(buck_one_code_applied));
        end
    end

    // ========================================
    // decoded configuration outputs
    function automatic logic [10:0] ilim_ma(input logic [1:0] code);
        case (code)
            2'h0: ilim_ma = ILIM_0_MA;
            2'h1: ilim_ma = ILIM_1_MA;
            2'h2: ilim_ma = ILIM_2_MA;
            default: ilim_ma = ILIM_3_MA;
        endcase
    endfunction

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            third_switch_limit_ma <= ILIM_0_MA;
            second_switch_limit_ma <= ILIM_0_MA;
            buck_one_pfm <= RST_BUCK[BIT_PFM];
            undervolt_hysteresis_sel <= RST_LIMIT[BIT_UVLO_HYS];
        end else if (ce) begin
            third_switch_limit_ma <=
                ilim_ma(switch_limit_config[FLD_LS3_LO +: 2]);
            second_switch_limit_ma <=
                ilim_ma(switch_limit_config[FLD_LS2_LO +: 2]);
            buck_one_pfm <= buck_one_voltage[BIT_PFM];
            undervolt_hysteresis_sel <= switch_limit_config[BIT_UVLO_HYS];
        end
    end

    // per switch: power-fail cut-off and discharge only while off
    genvar s;
    for (s = 0; s < 3; s++) begin : g_sw
        logic on_now;
        assign on_now = switch_enable[s] && !(pfo_low_sync == 1'b0 &&
            switch_failsafe_config[FLD_FAILOFF_LO + s]);
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                switch_on[s] <= 1'b0;
                switch_discharge[s] <= 1'b0;
            end else if (ce) begin
                switch_on[s] <= on_now;
                switch_discharge[s] <= !on_now &&
                    switch_failsafe_config[FLD_DISCH_LO + s];
            end
        end
    end

    // ========================================
    // pin three: warm-reset input or general output (enable low = drive)
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            general_pin_three_out <= 1'b0;
            general_pin_three_oe_n <= 1'b1;
            buck_warm_reset <= 1'b0;
        end else if (ce) begin
            if (switch_limit_config[BIT_WARM_RST]) begin
                general_pin_three_oe_n <= 1'b1;
                general_pin_three_out <= 1'b0;
                buck_warm_reset <= !pin3_sync;
            end else begin
                general_pin_three_oe_n <= 1'b0;
                general_pin_three_out <= gpo_three_level;
                buck_warm_reset <= 1'b0;
            end
        end
    end

    // ========================================
    // checks
    a_lock_gate: assert property (@(posedge clk) disable iff (!rstn)
        (ce && reg_wr && prot_hit && lock_state == PMSW_LOCKED)
        |=> ($stable(buck_one_voltage) && $stable(switch_limit_config)
        && write_rejected))
        else $error("protected register changed without unlock");
    a_resv_zero: assert property (@(posedge clk) disable iff (!rstn)
        (buck_one_voltage[6] == 1'b0) && (switch_limit_config[5:4] == 2'h0)
        && (switch_failsafe_config[7:6] == 2'h0))
        else $error("reserved bit set");
    a_reset_vals: assert property (@(posedge clk)
        $rose(rstn) |-> (switch_limit_config == 8'h40 &&
        switch_failsafe_config == 8'h00 && buck_one_voltage == 8'h80))
        else $error("wrong value after reset");
    a_blank_fault: assert property (@(posedge clk) disable iff (!rstn)
        (ce && wr_ok && reg_addr == OFS_BUCK) ##1 ce |=> buck_monitor_blank
        && ov_uv_fault == 2'h0)
        else $error("fault not blanked after buck write");
    a_commit_wait: assert property (@(posedge clk) disable iff (!rstn)
        (!commit_go && !commit_go_discharge) |=> $stable(buck_one_code_applied))
        else $error("code applied without commit");
    a_commit_take: assert property (@(posedge clk) disable iff (!rstn)
        (ce && commit_go) |=> buck_one_code_applied ==
        $past(buck_one_voltage[5:0]))
        else $error("commit did not apply code");
    a_limit_top: assert property (@(posedge clk) disable iff (!rstn)
        (ce && switch_limit_config[3:2] == 2'h3) |=>
        third_switch_limit_ma == 11'h3E8)
        else $error("third switch limit decode wrong");
    a_limit_two: assert property (@(posedge clk) disable iff (!rstn)
        (ce && switch_limit_config[1:0] == 2'h2) |=>
        second_switch_limit_ma == 11'h1F4)
        else $error("second switch limit decode wrong");
    a_fail_cut: assert property (@(posedge clk) disable iff (!rstn)
        (ce && switch_failsafe_config[5] && !pfo_low_sync) |=> !switch_on[2])
        else $error("switch three stayed on in power fail");
    a_disch_off: assert property (@(posedge clk) disable iff (!rstn)
        (switch_on & switch_discharge) == 3'h0)
        else $error("discharge while switch on");
    a_pfm_follow: assert property (@(posedge clk) disable iff (!rstn)
        ce |=> buck_one_pfm == $past(buck_one_voltage[7]))
        else $error("pfm output does not follow bit 7");
    a_mv_map: assert property (@(posedge clk) disable iff (!rstn)
        (ce && buck_one_code_applied == VOUT_LINEAR_MAX) |=>
        buck_one_target_mv == 11'd1200)
        else $error("voltage map wrong at top linear code");
    a_pin_role: assert property (@(posedge clk) disable iff (!rstn)
        (ce && switch_limit_config[7]) |=> general_pin_three_oe_n)
        else $error("pin three driven while warm-reset input");
endmodule

// ===== tb_pmsw_top.sv
// Purpose: self-checking bench for the switch and buck-one config registers
// Assumes: blanking shortened to 20 cycles, register port one cycle reads
// Notes: expected values come from the register table, not from the design
`timescale 1ns/1ns
module tb_pmsw_top;
    import pmsw_pkg::*;
    localparam int BLANK_SIM = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic commit_go = 1'b0;
    logic commit_go_discharge = 1'b0;
    logic power_fail_out_low = 1'b1;
    logic [2:0] switch_enable = 3'h7;
    logic gpo_three_level = 1'b0;
    logic general_pin_three_in = 1'b1;
    logic general_pin_three_out, general_pin_three_oe_n, buck_warm_reset;
    logic undervolt_hysteresis_sel, buck_one_pfm, buck_commit_discharge;
    logic [10:0] third_switch_limit_ma, second_switch_limit_ma;
    logic [10:0] buck_one_target_mv;
    logic [2:0] switch_on, switch_discharge;
    logic [5:0] buck_one_code_applied;
    logic buck_monitor_blank;
    logic [1:0] ov_uv_raw = 2'h0;
    logic [1:0] ov_uv_fault;
    int err_total = 0;
    int comparisons = 0;
    logic [10:0] lim_tab [4] = '{11'h064, 11'h0C8, 11'h1F4, 11'h3E8};
    logic [7:0] d;

    pmsw_top #(.BLANK_CYCLES_P(BLANK_SIM)) pmsw_top_inst (
        .clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .commit_go(commit_go),
        .commit_go_discharge(commit_go_discharge),
        .power_fail_out_low(power_fail_out_low),
        .switch_enable(switch_enable), .gpo_three_level(gpo_three_level),
        .general_pin_three_in(general_pin_three_in),
        .general_pin_three_out(general_pin_three_out),
        .general_pin_three_oe_n(general_pin_three_oe_n),
        .buck_warm_reset(buck_warm_reset),
        .undervolt_hysteresis_sel(undervolt_hysteresis_sel),
        .third_switch_limit_ma(third_switch_limit_ma),
        .second_switch_limit_ma(second_switch_limit_ma),
        .switch_on(switch_on), .switch_discharge(switch_discharge),
        .buck_one_pfm(buck_one_pfm),
        .buck_one_code_applied(buck_one_code_applied),
        .buck_one_target_mv(buck_one_target_mv),
        .buck_commit_discharge(buck_commit_discharge),
        .buck_monitor_blank(buck_monitor_blank),
        .ov_uv_raw(ov_uv_raw), .ov_uv_fault(ov_uv_fault)
    );

    // ========================================
    // clock and shared tasks
    always #50 clk = ~clk;

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one-cycle write strobe; the leading edge keeps strobes from colliding
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // unlock then write; the key only arms the very next write
    task automatic pwr(input logic [7:0] a, input logic [7:0] v);
        wr(OFS_UNLOCK, UNLOCK_KEY);
        wr(a, v);
    endtask

    // read data are valid only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ========================================
    // watchdog: tests need well under a thousand cycles
    initial begin
        #(5000 * 100);
        err_total++;
        summarize();
    end

    // ========================================
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(OFS_LIMIT, d);
        check("limit reset", d, 16'h0040);
        rd(OFS_FAILSAFE, d);
        check("failsafe reset", d, 16'h0000);
        rd(OFS_BUCK, d);
        check("buck reset", d, 16'h0080);
        check("pfm reset", buck_one_pfm, 16'h0001);
        check("target reset", buck_one_target_mv, 16'h0352);
        check("hyst reset", undervolt_hysteresis_sel, 16'h0001);
        $display("test reset values done");

        // a write without the key must be dropped and flagged
        wr(OFS_BUCK, 8'h15);
        rd(OFS_BUCK, d);
        check("locked write", d, 16'h0080);
        rd(OFS_UNLOCK, d);
        check("reject flag", d[1], 16'h0001);
        $display("test lock done");

        // every limit code, reserved bits written high
        for (int i = 0; i < 4; i++) begin
            pwr(OFS_LIMIT, 8'h30 | 8'(i << 2) | 8'(i));
            rd(OFS_LIMIT, d);
            check("limit reg", d, 16'(8'(i << 2) | 8'(i)));
            idle(2);
            check("third limit", third_switch_limit_ma, lim_tab[i]);
            check("second limit", second_switch_limit_ma,
                  lim_tab[i]);
            pwr(OFS_LIMIT, 8'(i << 2) | 8'(3 - i));
            idle(2);
            check("second mixed", second_switch_limit_ma,
                  lim_tab[3 - i]);
        end
        $display("test limits done");

        // pin three as warm-reset input, then as plain output
        pwr(OFS_LIMIT, 8'h80);
        general_pin_three_in <= 1'b0;
        idle(7);
        check("warm reset", buck_warm_reset, 16'h0001);
        check("pin released", general_pin_three_oe_n, 16'h0001);
        general_pin_three_in <= 1'b1;
        idle(7);
        check("warm reset off", buck_warm_reset, 16'h0000);
        pwr(OFS_LIMIT, 8'h00);
        gpo_three_level <= 1'b1;
        idle(3);
        check("pin driven", general_pin_three_oe_n, 16'h0000);
        check("pin level", general_pin_three_out, 16'h0001);
        $display("test pin three done");

        // power-fail off and discharge per switch
        pwr(OFS_FAILSAFE, 8'hC6 | 8'h28);
        rd(OFS_FAILSAFE, d);
        check("failsafe reg", d, 16'h002E);
        idle(2);
        check("switches on", switch_on, 16'h0007);
        check("no discharge", switch_discharge, 16'h0000);
        power_fail_out_low <= 1'b0;
        idle(8);
        check("fail off", switch_on, 16'h0002);
        check("discharge", switch_discharge, 16'h0004);
        switch_enable <= 3'h0;
        idle(3);
        check("discharge all", switch_discharge, 16'h0006);
        switch_enable <= 3'h7;
        power_fail_out_low <= 1'b1;
        idle(8);
        check("fail cleared", switch_on, 16'h0007);
        $display("test failsafe done");

        // buck write: blanking, pwm, code waits for commit
        ov_uv_raw <= 2'h3;
        pwr(OFS_BUCK, 8'h63);
        idle(2);
        check("blank on", buck_monitor_blank, 16'h0001);
        check("fault masked", ov_uv_fault, 16'h0000);
        check("pwm forced", buck_one_pfm, 16'h0000);
        rd(OFS_BUCK, d);
        check("buck reg", d, 16'h0023);
        check("no commit yet", buck_one_code_applied, 16'h0000);
        idle(BLANK_SIM + 4);
        check("blank off", buck_monitor_blank, 16'h0000);
        check("fault seen", ov_uv_fault, 16'h0003);
        commit_go <= 1'b1;
        @(posedge clk);
        commit_go <= 1'b0;
        idle(2);
        check("applied", buck_one_code_applied, 16'h0023);
        check("target max", buck_one_target_mv, 16'h04B0);
        pwr(OFS_BUCK, 8'h85);
        idle(2);
        check("pfm on", buck_one_pfm, 16'h0001);
        commit_go_discharge <= 1'b1;
        @(posedge clk);
        commit_go_discharge <= 1'b0;
        #1 check("commit dis", buck_commit_discharge, 16'h0001);
        idle(2);
        check("applied dis", buck_one_code_applied, 16'h0005);
        check("target", buck_one_target_mv, 16'h0384);
        // clock enable low must freeze the commit path
        pwr(OFS_BUCK, 8'h8A);
        ce <= 1'b0;
        commit_go <= 1'b1;
        idle(3);
        check("ce frozen", buck_one_code_applied, 16'h0005);
        ce <= 1'b1;
        @(posedge clk);
        commit_go <= 1'b0;
        idle(1);
        check("ce running", buck_one_code_applied, 16'h000A);
        ov_uv_raw <= 2'h0;
        $display("test buck one done");
        summarize();
    end
endmodule
